/* File: include/socfg_pkg.sv */
/*
 * Register map, reset values and field positions of the output
 * synthesizer configuration bank.
 * Assumes a 32-bit APB master; each register index sits at byte address 4*index.
 */
`default_nettype none
package socfg_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_PRIO_01 = 8'h31;
    localparam logic [7:0] IDX_PRIO_23 = 8'h32;
    localparam logic [7:0] IDX_PRIO_45 = 8'h33;
    localparam logic [7:0] IDX_PRIO_67 = 8'h34;
    localparam logic [7:0] IDX_LOCK_STATE = 8'h35;
    localparam logic [7:0] IDX_A_ENABLES = 8'h36;
    localparam logic [7:0] IDX_A_GENERATE = 8'h37;
    localparam logic [7:0] IDX_A_MULT_LOW = 8'h38;
    localparam logic [7:0] IDX_A_MULT_HIGH = 8'h39;
    localparam logic [7:0] IDX_A_CLKA_COARSE = 8'h3A;
    localparam logic [7:0] IDX_A_CLKB_DIVIDER = 8'h3B;
    localparam logic [7:0] IDX_A_CLKB_COARSE = 8'h3C;
    localparam logic [7:0] IDX_A_FINE = 8'h3D;
    localparam logic [7:0] IDX_A_PA_RATE = 8'h3E;
    localparam logic [7:0] IDX_A_PA_STYLE = 8'h3F;
    localparam logic [7:0] IDX_A_PA_SHIFT_LO = 8'h40;
    localparam logic [7:0] IDX_A_PA_SHIFT_MID = 8'h41;
    localparam logic [7:0] IDX_A_PA_SHIFT_HI = 8'h42;
    localparam logic [7:0] IDX_A_PB_RATE = 8'h43;
    localparam logic [7:0] IDX_A_PB_STYLE = 8'h44;
    localparam logic [7:0] IDX_A_PB_SHIFT_LO = 8'h45;
    localparam logic [7:0] IDX_A_PB_SHIFT_MID = 8'h46;
    localparam logic [7:0] IDX_A_PB_SHIFT_HI = 8'h47;
    localparam logic [7:0] IDX_B_ENABLES = 8'h48;
    localparam logic [7:0] IDX_B_GENERATE = 8'h49;
    localparam logic [7:0] IDX_B_MULT_LOW = 8'h4A;
    localparam logic [7:0] IDX_B_MULT_HIGH = 8'h4B;
    localparam logic [7:0] IDX_B_CLKA_COARSE = 8'h4C;
    localparam logic [7:0] IDX_B_CLKB_DIVIDER = 8'h4D;
    localparam logic [7:0] IDX_B_CLKB_COARSE = 8'h4E;
    localparam logic [7:0] IDX_B_FINE = 8'h4F;
    localparam logic [7:0] IDX_S_ENABLES = 8'h50;
    localparam logic [7:0] IDX_S_GENERATE = 8'h51;
    localparam logic [7:0] IDX_S_CLOCK_SEL = 8'h52;
    localparam logic [7:0] IDX_S_CLKA_COARSE = 8'h53;
    localparam logic [7:0] IDX_S_CLKB_COARSE = 8'h54;
    localparam logic [7:0] IDX_S_FINE = 8'h55;
    localparam int NREG = 37;

    // Interrupt registers
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h81;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h82;

    // ************************************************************
    // Reset values, index 0x55 in the top byte, 0x31 in the bottom
    // ************************************************************
    localparam logic [NREG*8-1:0] REG_RESET = {
        8'h00, 8'h00, 8'h00, 8'h42, 8'h0F, 8'h8F,
        8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'hC1, 8'h03, 8'h83,
        8'h00, 8'h00, 8'h00, 8'h11, 8'h05,
        8'h00, 8'h00, 8'h00, 8'h83, 8'h05,
        8'h00, 8'h00, 8'h3E, 8'h00, 8'h01, 8'h00, 8'h0F, 8'h8F,
        8'h04, 8'h76, 8'h54, 8'h32, 8'h10};
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int EN_SYNTH_BIT = 7;
    localparam int LOCK_BIT = 0;
    localparam int HOLDOVER_BIT = 1;
    localparam int FREERUN_BIT = 2;
    localparam int EV_LOCK_GAINED = 0;
    localparam int EV_LOCK_LOST = 1;
    localparam int EV_HOLDOVER = 2;

endpackage : socfg_pkg
`default_nettype wire

/* File: hw/socfg_regs.sv */
/*
 * APB register bank for the secondary tracking loop, synth_a, synth_b
 * and the SONET path outputs, with lock-event interrupts.
 * Assumes an APB master on CORE_CLK and loop status levels from another domain.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Four registers hold two priority values each for references zero to seven.
// - Read-only lock and holdover status of the secondary loop, reset 04.
// - synth_a enable register gates two clocks, two pulses, synthesizer, source.
// - synth_a run register controls generation of its clocks and pulses.
// - synth_a first clock is N times 8 kHz, 14-bit N over two registers.
// - synth_a first pulse has a 22-bit offset, fine low and coarse high.
// - synth_a second pulse has its own 22-bit offset in three registers.
// - synth_a second clock divider register, reset 3E, plus coarse phase per clock.
// - Each output path has a fine alignment register reset to zero.
// - Each synth_a pulse has rate and style registers with given resets.
// - synth_b enable register gates two clocks, synthesizer and source.
// - synth_b run register controls generation of its two clocks.
// - synth_b first clock N times 8 kHz, reset C1 low, 00 high.
// - SONET path enable register gates two clocks, two pulses and PLL.
// - SONET path run register controls its clocks and pulses.
// - One shared register selects both SONET path clock frequencies.
// - Each SONET and synth_b clock has a coarse phase register.
module socfg_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic LOOP_LOCKED,
    input wire logic LOOP_HOLDOVER,
    output logic IRQ,
    output logic [31:0] LOOP_PRIORITIES,
    output logic [3:0] SYNTH_A_RUNNING,
    output logic [3:0] SYNTH_A_HOLD,
    output logic [2:0] SYNTH_A_SOURCE,
    output logic [13:0] SYNTH_A_MULT,
    output logic [21:0] SYNTH_A_PULSE_A_SHIFT,
    output logic [21:0] SYNTH_A_PULSE_B_SHIFT,
    output logic [31:0] SYNTH_A_PULSE_RATE_STYLE,
    output logic [15:0] CLOCK_DIVIDERS,
    output logic [47:0] COARSE_PHASES,
    output logic [23:0] FINE_ALIGNS,
    output logic [1:0] SYNTH_B_RUNNING,
    output logic [1:0] SYNTH_B_HOLD,
    output logic [2:0] SYNTH_B_SOURCE,
    output logic [13:0] SYNTH_B_MULT,
    output logic [3:0] SONET_RUNNING,
    output logic [3:0] SONET_HOLD,
    output logic [7:0] SONET_CLOCK_SELECT
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [socfg_pkg::NREG-1:0][7:0] regs;
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic [2:0] lock_prev;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic irq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic [3:0] a_run;
        logic [3:0] a_hold;
        logic [1:0] b_run;
        logic [1:0] b_hold;
        logic [3:0] s_run;
        logic [3:0] s_hold;
    } socfg_state_s;

    typedef enum {
        SOCFG_MISS,
        SOCFG_BANK,
        SOCFG_IRQ_STAT,
        SOCFG_IRQ_CLR,
        SOCFG_IRQ_EN
    } socfg_target_e;

    socfg_state_s st;
    socfg_state_s next_st;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic socfg_target_e decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'b00 || addr[ADDR_W-1:10] != '0) begin
            return SOCFG_MISS;
        end
        if (idx >= socfg_pkg::IDX_PRIO_01 && idx <= socfg_pkg::IDX_S_FINE) begin
            return SOCFG_BANK;
        end
        if (idx == socfg_pkg::IDX_IRQ_STATUS) begin
            return SOCFG_IRQ_STAT;
        end
        if (idx == socfg_pkg::IDX_IRQ_CLEAR) begin
            return SOCFG_IRQ_CLR;
        end
        if (idx == socfg_pkg::IDX_IRQ_ENABLE) begin
            return SOCFG_IRQ_EN;
        end
        return SOCFG_MISS;
    endfunction

    function automatic int slot(input logic [7:0] idx);
        return int'(idx - socfg_pkg::IDX_PRIO_01);
    endfunction

    // Running when synthesizer, output and run bit all set; held when run is clear
    function automatic logic [3:0] running(input logic [7:0] en, input logic [7:0] gen);
        return en[socfg_pkg::EN_SYNTH_BIT] ? (en[3:0] & gen[3:0]) : 4'h0;
    endfunction

    function automatic logic [3:0] holding(input logic [7:0] en, input logic [7:0] gen);
        return en[socfg_pkg::EN_SYNTH_BIT] ? (en[3:0] & ~gen[3:0]) : 4'h0;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        socfg_target_e tgt;
        logic [7:0] idx;
        logic [2:0] lock_now;
        logic [2:0] events;
        logic [3:0] tmp;
        tgt = SOCFG_MISS;
        idx = 8'h00;
        lock_now = 3'h0;
        events = 3'h0;
        tmp = 4'h0;
        next_st = st;
        tgt = decode(PADDR);
        idx = PADDR[9:2];

        // Loop status crosses in through two flops
        next_st.sync_a = {LOOP_HOLDOVER, LOOP_LOCKED};
        next_st.sync_b = st.sync_a;
        lock_now = 3'h0;
        lock_now[socfg_pkg::LOCK_BIT] = st.sync_b[0];
        lock_now[socfg_pkg::HOLDOVER_BIT] = st.sync_b[1] & ~st.sync_b[0];
        lock_now[socfg_pkg::FREERUN_BIT] = ~st.sync_b[0] & ~st.sync_b[1];
        next_st.regs[slot(socfg_pkg::IDX_LOCK_STATE)] = {5'h00, lock_now};
        next_st.lock_prev = lock_now;

        events = 3'h0;
        events[socfg_pkg::EV_LOCK_GAINED] = lock_now[socfg_pkg::LOCK_BIT] & ~st.lock_prev[socfg_pkg::LOCK_BIT];
        events[socfg_pkg::EV_LOCK_LOST] = ~lock_now[socfg_pkg::LOCK_BIT] & st.lock_prev[socfg_pkg::LOCK_BIT];
        events[socfg_pkg::EV_HOLDOVER] = lock_now[socfg_pkg::HOLDOVER_BIT]
            & ~st.lock_prev[socfg_pkg::HOLDOVER_BIT];

        // APB: one wait state, effect at the edge that samples pready high
        next_st.pready = PSEL & PENABLE & ~st.pready;
        next_st.pslverr = 1'b0;
        if (PSEL && PENABLE && !st.pready) begin
            next_st.pslverr = (tgt == SOCFG_MISS);
            next_st.prdata = 32'h0000_0000;
            if (!PWRITE) begin
                unique case (tgt)
                    SOCFG_BANK: next_st.prdata[7:0] = st.regs[slot(idx)];
                    SOCFG_IRQ_STAT: next_st.prdata[2:0] = st.irq_status;
                    SOCFG_IRQ_EN: next_st.prdata[2:0] = st.irq_enable;
                    SOCFG_IRQ_CLR, SOCFG_MISS: next_st.prdata = 32'h0000_0000;
                endcase
            end
        end

        if (PSEL && PENABLE && st.pready && PWRITE) begin
            unique case (tgt)
                SOCFG_BANK: begin
                    // Status register ignores writes
                    if (idx != socfg_pkg::IDX_LOCK_STATE) begin
                        next_st.regs[slot(idx)] = PWDATA[7:0];
                    end
                end
                SOCFG_IRQ_CLR: next_st.irq_status = st.irq_status & ~PWDATA[2:0];
                SOCFG_IRQ_EN: next_st.irq_enable = PWDATA[2:0];
                SOCFG_IRQ_STAT, SOCFG_MISS: next_st.irq_enable = st.irq_enable;
            endcase
        end

        // Set wins over a clear in the same cycle
        next_st.irq_status = next_st.irq_status | events;
        next_st.irq = |(next_st.irq_status & next_st.irq_enable);

        // Output gating follows the stored enable and run bytes
        next_st.a_run = running(next_st.regs[slot(socfg_pkg::IDX_A_ENABLES)],
            next_st.regs[slot(socfg_pkg::IDX_A_GENERATE)]);
        next_st.a_hold = holding(next_st.regs[slot(socfg_pkg::IDX_A_ENABLES)],
            next_st.regs[slot(socfg_pkg::IDX_A_GENERATE)]);
        tmp = running(next_st.regs[slot(socfg_pkg::IDX_B_ENABLES)],
            next_st.regs[slot(socfg_pkg::IDX_B_GENERATE)]);
        next_st.b_run = tmp[1:0];
        tmp = holding(next_st.regs[slot(socfg_pkg::IDX_B_ENABLES)],
            next_st.regs[slot(socfg_pkg::IDX_B_GENERATE)]);
        next_st.b_hold = tmp[1:0];
        next_st.s_run = running(next_st.regs[slot(socfg_pkg::IDX_S_ENABLES)],
            next_st.regs[slot(socfg_pkg::IDX_S_GENERATE)]);
        next_st.s_hold = holding(next_st.regs[slot(socfg_pkg::IDX_S_ENABLES)],
            next_st.regs[slot(socfg_pkg::IDX_S_GENERATE)]);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.regs <= socfg_pkg::REG_RESET;
            st.irq_enable <= socfg_pkg::IRQ_ENABLE_RESET;
            st.lock_prev <= 3'h4;
            st.a_run <= 4'hF;
            st.b_run <= 2'h3;
            st.s_run <= 4'hF;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs, all straight from state flops
    // ************************************************************
    assign PREADY = st.pready;
    assign PRDATA = st.prdata;
    assign PSLVERR = st.pslverr;
    assign IRQ = st.irq;
    assign LOOP_PRIORITIES = {st.regs[slot(socfg_pkg::IDX_PRIO_67)], st.regs[slot(socfg_pkg::IDX_PRIO_45)],
        st.regs[slot(socfg_pkg::IDX_PRIO_23)], st.regs[slot(socfg_pkg::IDX_PRIO_01)]};
    assign SYNTH_A_RUNNING = st.a_run;
    assign SYNTH_A_HOLD = st.a_hold;
    assign SYNTH_A_SOURCE = st.regs[slot(socfg_pkg::IDX_A_ENABLES)][6:4];
    assign SYNTH_A_MULT = {st.regs[slot(socfg_pkg::IDX_A_MULT_HIGH)][5:0],
        st.regs[slot(socfg_pkg::IDX_A_MULT_LOW)]};
    // Low 16 bits count fast-clock periods, top 6 count whole 8 kHz frames
    assign SYNTH_A_PULSE_A_SHIFT = {st.regs[slot(socfg_pkg::IDX_A_PA_SHIFT_HI)][5:0],
        st.regs[slot(socfg_pkg::IDX_A_PA_SHIFT_MID)],
        st.regs[slot(socfg_pkg::IDX_A_PA_SHIFT_LO)]};
    assign SYNTH_A_PULSE_B_SHIFT = {st.regs[slot(socfg_pkg::IDX_A_PB_SHIFT_HI)][5:0],
        st.regs[slot(socfg_pkg::IDX_A_PB_SHIFT_MID)],
        st.regs[slot(socfg_pkg::IDX_A_PB_SHIFT_LO)]};
    assign SYNTH_A_PULSE_RATE_STYLE = {st.regs[slot(socfg_pkg::IDX_A_PB_STYLE)],
        st.regs[slot(socfg_pkg::IDX_A_PB_RATE)], st.regs[slot(socfg_pkg::IDX_A_PA_STYLE)],
        st.regs[slot(socfg_pkg::IDX_A_PA_RATE)]};
    assign CLOCK_DIVIDERS = {st.regs[slot(socfg_pkg::IDX_B_CLKB_DIVIDER)],
        st.regs[slot(socfg_pkg::IDX_A_CLKB_DIVIDER)]};
    assign COARSE_PHASES = {st.regs[slot(socfg_pkg::IDX_S_CLKB_COARSE)],
        st.regs[slot(socfg_pkg::IDX_S_CLKA_COARSE)],
        st.regs[slot(socfg_pkg::IDX_B_CLKB_COARSE)], st.regs[slot(socfg_pkg::IDX_B_CLKA_COARSE)],
        st.regs[slot(socfg_pkg::IDX_A_CLKB_COARSE)],
        st.regs[slot(socfg_pkg::IDX_A_CLKA_COARSE)]};
    assign FINE_ALIGNS = {st.regs[slot(socfg_pkg::IDX_S_FINE)], st.regs[slot(socfg_pkg::IDX_B_FINE)],
        st.regs[slot(socfg_pkg::IDX_A_FINE)]};
    assign SYNTH_B_RUNNING = st.b_run;
    assign SYNTH_B_HOLD = st.b_hold;
    assign SYNTH_B_SOURCE = st.regs[slot(socfg_pkg::IDX_B_ENABLES)][6:4];
    assign SYNTH_B_MULT = {st.regs[slot(socfg_pkg::IDX_B_MULT_HIGH)][5:0],
        st.regs[slot(socfg_pkg::IDX_B_MULT_LOW)]};
    assign SONET_RUNNING = st.s_run;
    assign SONET_HOLD = st.s_hold;
    assign SONET_CLOCK_SELECT = st.regs[slot(socfg_pkg::IDX_S_CLOCK_SEL)];

endmodule // socfg_regs
`default_nettype wire

/* File: testbench/socfg_regs_sva.sv */
/* Checker for the output synthesizer register bank: APB answer timing, refusals, run/hold gating.
   Assumes it is bound to socfg_regs and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module socfg_regs_sva #(
    parameter int ADDR_W = 12
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic [3:0] SYNTH_A_RUNNING,
    input wire logic [3:0] SYNTH_A_HOLD,
    input wire logic [1:0] SYNTH_B_RUNNING,
    input wire logic [3:0] SONET_RUNNING,
    input wire logic [3:0] SONET_HOLD
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_ready_after; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_ready_after: assert property (p_ready_after) else $error("ready late");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_ready_cause; PREADY |-> PSEL && PENABLE; endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready outside access");
    property p_err_read; PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0000_0000); endproperty
    a_err_read: assert property (p_err_read) else $error("bad error answer");
    property p_byte_read; PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000; endproperty
    a_byte_read: assert property (p_byte_read) else $error("upper read bits set");
    // Run bits just written decide running against held
    property p_gen_write;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_W'(12'h0DC) |=>
        ({28'h000_0000, SYNTH_A_RUNNING} & ~$past(PWDATA)) == 32'h0000_0000
        && ({28'h000_0000, SYNTH_A_HOLD} & $past(PWDATA)) == 32'h0000_0000;
    endproperty
    a_gen_write: assert property (p_gen_write) else $error("run write not applied");
    property p_a_excl; (SYNTH_A_RUNNING & SYNTH_A_HOLD) == 4'h0; endproperty
    a_a_excl: assert property (p_a_excl) else $error("output both run and hold");
    property p_s_excl; (SONET_RUNNING & SONET_HOLD) == 4'h0; endproperty
    a_s_excl: assert property (p_s_excl) else $error("sonet both run and hold");
    property p_reset_runs;
        $fell(RST) |-> SYNTH_A_RUNNING == 4'hF && SYNTH_B_RUNNING == 2'h3 && SONET_RUNNING == 4'hF;
    endproperty
    a_reset_runs: assert property (p_reset_runs) else $error("outputs idle after reset");
endmodule // socfg_regs_sva
bind socfg_regs socfg_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .SYNTH_A_RUNNING(SYNTH_A_RUNNING), .SYNTH_A_HOLD(SYNTH_A_HOLD),
    .SYNTH_B_RUNNING(SYNTH_B_RUNNING), .SONET_RUNNING(SONET_RUNNING), .SONET_HOLD(SONET_HOLD));
`default_nettype wire

/* File: testbench/tb_top.sv */
/* Self-checking bench for the output synthesizer register bank.
   Assumes a 40 MHz clock, APB at byte address 4*index, loop status driven directly. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ************************************************************
    // Signals and expectations
    // ************************************************************
    logic CORE_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic LOOP_LOCKED = 1'b0, LOOP_HOLDOVER = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic PREADY, PSLVERR, IRQ;
    logic [31:0] PRDATA, LOOP_PRIORITIES, SYNTH_A_PULSE_RATE_STYLE;
    logic [3:0] SYNTH_A_RUNNING, SYNTH_A_HOLD, SONET_RUNNING, SONET_HOLD;
    logic [2:0] SYNTH_A_SOURCE, SYNTH_B_SOURCE;
    logic [13:0] SYNTH_A_MULT, SYNTH_B_MULT;
    logic [21:0] SYNTH_A_PULSE_A_SHIFT, SYNTH_A_PULSE_B_SHIFT;
    logic [15:0] CLOCK_DIVIDERS;
    logic [47:0] COARSE_PHASES;
    logic [23:0] FINE_ALIGNS;
    logic [1:0] SYNTH_B_RUNNING, SYNTH_B_HOLD;
    logic [7:0] SONET_CLOCK_SELECT;
    int num_errors = 0, n_compared = 0;
    logic [7:0] s [8'h31:8'h55];
    logic [33:0] q [$];
    logic [33:0] m;
    localparam logic [7:0] RV [37] = '{8'h10, 8'h32, 8'h54, 8'h76, 8'h04, 8'h8F, 8'h0F, 8'h00, 8'h01, 8'h00,
        8'h3E, 8'h00, 8'h00, 8'h05, 8'h83, 8'h00, 8'h00, 8'h00, 8'h05, 8'h11, 8'h00, 8'h00, 8'h00, 8'h83,
        8'h03, 8'hC1, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h8F, 8'h0F, 8'h42, 8'h00, 8'h00, 8'h00};
    always #12.5 CORE_CLK = ~CORE_CLK;
    socfg_regs dut (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
        .LOOP_LOCKED(LOOP_LOCKED), .LOOP_HOLDOVER(LOOP_HOLDOVER), .IRQ(IRQ), .LOOP_PRIORITIES(LOOP_PRIORITIES),
        .SYNTH_A_RUNNING(SYNTH_A_RUNNING), .SYNTH_A_HOLD(SYNTH_A_HOLD), .SYNTH_A_SOURCE(SYNTH_A_SOURCE),
        .SYNTH_A_MULT(SYNTH_A_MULT), .SYNTH_A_PULSE_A_SHIFT(SYNTH_A_PULSE_A_SHIFT),
        .SYNTH_A_PULSE_B_SHIFT(SYNTH_A_PULSE_B_SHIFT), .SYNTH_A_PULSE_RATE_STYLE(SYNTH_A_PULSE_RATE_STYLE),
        .CLOCK_DIVIDERS(CLOCK_DIVIDERS), .COARSE_PHASES(COARSE_PHASES), .FINE_ALIGNS(FINE_ALIGNS),
        .SYNTH_B_RUNNING(SYNTH_B_RUNNING), .SYNTH_B_HOLD(SYNTH_B_HOLD), .SYNTH_B_SOURCE(SYNTH_B_SOURCE),
        .SYNTH_B_MULT(SYNTH_B_MULT), .SONET_RUNNING(SONET_RUNNING), .SONET_HOLD(SONET_HOLD),
        .SONET_CLOCK_SELECT(SONET_CLOCK_SELECT));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_sim();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic fail(input string t);
        num_errors++;
        $display("MISMATCH %0t %s", $time, t);
    endtask
    task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string t);
        n_compared++;
        if (got !== exp) fail(t);
    endtask
    // Idle cycle after each transfer keeps one assignment per signal per step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        int i;
        PSEL <= 1'b1;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        q.push_back({w, err, e});
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 20 && PREADY !== 1'b1; i++) @(posedge CORE_CLK);
        if (i == 20) begin
            fail("no ready");
            end_sim();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic wr(input logic [7:0] x, input logic [31:0] d);
        if (x >= 8'h31 && x <= 8'h55 && x != 8'h35) s[x] = d[7:0];
        apb({2'b00, x, 2'b00}, 1'b1, d, 32'h0000_0000, 1'b0);
    endtask
    task automatic rd(input logic [7:0] x, input logic [7:0] e);
        apb({2'b00, x, 2'b00}, 1'b0, 32'h0000_0000, {24'h00_0000, e}, 1'b0);
    endtask
    // Loop status needs two sync flops plus the status flop before IRQ moves
    task automatic irq_is(input logic v);
        repeat (4) @(posedge CORE_CLK);
        cmp(IRQ, v, "irq level");
    endtask
    task automatic outs();
        logic [7:0] ea, ga, eb, gb, es, gs;
        ea = s[8'h36];
        ga = s[8'h37];
        eb = s[8'h48];
        gb = s[8'h49];
        es = s[8'h50];
        gs = s[8'h51];
        cmp(LOOP_PRIORITIES, {s[8'h34], s[8'h33], s[8'h32], s[8'h31]}, "prio");
        cmp(SYNTH_A_RUNNING, {4{ea[7]}} & ea[3:0] & ga[3:0], "a run");
        cmp(SYNTH_A_HOLD, {4{ea[7]}} & ea[3:0] & ~ga[3:0], "a hold");
        cmp(SYNTH_A_SOURCE, ea[6:4], "a src");
        cmp(SYNTH_A_MULT, {s[8'h39][5:0], s[8'h38]}, "a mult");
        cmp(SYNTH_A_PULSE_A_SHIFT, {s[8'h42][5:0], s[8'h41], s[8'h40]}, "pa shift");
        cmp(SYNTH_A_PULSE_B_SHIFT, {s[8'h47][5:0], s[8'h46], s[8'h45]}, "pb shift");
        cmp(SYNTH_A_PULSE_RATE_STYLE, {s[8'h44], s[8'h43], s[8'h3F], s[8'h3E]}, "pulse");
        cmp(CLOCK_DIVIDERS, {s[8'h4D], s[8'h3B]}, "div");
        cmp(COARSE_PHASES, {s[8'h54], s[8'h53], s[8'h4E], s[8'h4C], s[8'h3C], s[8'h3A]}, "coarse");
        cmp(FINE_ALIGNS, {s[8'h55], s[8'h4F], s[8'h3D]}, "fine");
        cmp(SYNTH_B_RUNNING, {2{eb[7]}} & eb[1:0] & gb[1:0], "b run");
        cmp(SYNTH_B_HOLD, {2{eb[7]}} & eb[1:0] & ~gb[1:0], "b hold");
        cmp(SYNTH_B_SOURCE, eb[6:4], "b src");
        cmp(SYNTH_B_MULT, {s[8'h4B][5:0], s[8'h4A]}, "b mult");
        cmp(SONET_RUNNING, {4{es[7]}} & es[3:0] & gs[3:0], "s run");
        cmp(SONET_HOLD, {4{es[7]}} & es[3:0] & ~gs[3:0], "s hold");
        cmp(SONET_CLOCK_SELECT, s[8'h52], "s sel");
    endtask
    task automatic reset_pass();
        for (int i = 0; i < 37; i++) s[8'h31 + i] = RV[i];
        repeat (12) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        for (int i = 0; i < 37; i++) rd(8'(8'h31 + i), RV[i]);
        outs();
    endtask
    // ************************************************************
    // Answer monitor and main sequence
    // ************************************************************
    always @(posedge CORE_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1) begin
            if (q.size() == 0) fail("unexpected answer");
            else begin
                m = q.pop_front();
                n_compared++;
                if (PSLVERR !== m[32] || (!m[33] && PRDATA !== m[31:0])) fail("apb answer");
            end
        end
    end
    initial begin
        void'($urandom(32'he2bb));
        reset_pass();
        for (int i = 0; i < 37; i++) wr(8'(8'h31 + i), $urandom);
        for (int i = 0; i < 37; i++) rd(8'(8'h31 + i), s[8'h31 + i]);
        outs();
        wr(8'h36, 32'h0000_008F);
        wr(8'h37, 32'h0000_0005);
        outs();
        wr(8'h37, 32'h0000_000F);
        outs();
        apb(12'h000, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        apb(12'h0C5, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1);
        rd(8'h81, 8'h00);
        wr(8'h82, 32'h0000_0007);
        rd(8'h82, 8'h07);
        LOOP_LOCKED <= 1'b1;
        irq_is(1'b1);
        irq_is(1'b1);
        rd(8'h35, 8'h01);
        rd(8'h80, 8'h01);
        wr(8'h81, 32'h0000_0001);
        irq_is(1'b0);
        wr(8'h82, 32'h0000_0000);
        LOOP_LOCKED <= 1'b0;
        LOOP_HOLDOVER <= 1'b1;
        irq_is(1'b0);
        irq_is(1'b0);
        rd(8'h35, 8'h02);
        rd(8'h80, 8'h06);
        wr(8'h82, 32'h0000_0004);
        irq_is(1'b1);
        wr(8'h81, 32'h0000_0007);
        irq_is(1'b0);
        rd(8'h80, 8'h00);
        LOOP_HOLDOVER <= 1'b0;
        repeat (6) @(posedge CORE_CLK);
        rd(8'h35, 8'h04);
        RST <= 1'b1;
        reset_pass();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
